// *** hw/ccp_pkg.sv ***
// Constants shared by the capture/compare/PWM unit and its helpers.
// Assumes the plain register port and the 8-bit base timers live outside.
package ccp_pkg;

    // ----------------------------------------
    // Register indices on the plain port
    // ----------------------------------------
    localparam logic [1:0] ADDR_CONTROL      = 2'h0;
    localparam logic [1:0] ADDR_DUTY_LOW     = 2'h1;
    localparam logic [1:0] ADDR_DUTY_HIGH    = 2'h2;
    localparam logic [1:0] ADDR_TIMER_CHOICE = 2'h3;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int CTL_EN_BIT     = 7;
    localparam int CTL_OE_BIT     = 6;
    localparam int CTL_OUT_BIT    = 5;
    localparam int CTL_ALIGN_BIT  = 4;
    localparam int UNIT1_SEL_LSB  = 0;
    localparam int UNIT2_SEL_LSB  = 2;

    // ----------------------------------------
    // Reset values and masks
    // ----------------------------------------
    localparam logic [7:0] CONTROL_RST       = 8'h00;
    localparam logic [7:0] DUTY_RST          = 8'h00;
    localparam logic [7:0] TIMER_CHOICE_RST  = 8'h00;
    localparam logic [7:0] TIMER_CHOICE_MASK = 8'h0F;
    localparam logic [7:0] CONTROL_WR_MASK   = 8'hDF;
    localparam logic [1:0] TIMER_SEL_RSVD    = 2'h3;

    // ----------------------------------------
    // Mode codes
    // ----------------------------------------
    localparam logic [3:0] MODE_OFF           = 4'h0;
    localparam logic [3:0] MODE_CMP_TOGGLE_CL = 4'h1;
    localparam logic [3:0] MODE_CMP_TOGGLE    = 4'h2;
    localparam logic [3:0] MODE_CAP_BOTH      = 4'h3;
    localparam logic [3:0] MODE_CAP_FALL      = 4'h4;
    localparam logic [3:0] MODE_CAP_RISE      = 4'h5;
    localparam logic [3:0] MODE_CAP_RISE4     = 4'h6;
    localparam logic [3:0] MODE_CAP_RISE16    = 4'h7;
    localparam logic [3:0] MODE_CMP_SET       = 4'h8;
    localparam logic [3:0] MODE_CMP_CLEAR     = 4'h9;
    localparam logic [3:0] MODE_CMP_PULSE     = 4'hA;
    localparam logic [3:0] MODE_CMP_PULSE_CL  = 4'hB;

    // ----------------------------------------
    // Timing counts
    // ----------------------------------------
    localparam logic [3:0] CAP_EVERY4_LAST  = 4'h3;
    localparam logic [3:0] CAP_EVERY16_LAST = 4'hF;
    localparam logic [3:0] CAP_EVERY1_LAST  = 4'h0;
    localparam logic [1:0] SYSCLK_PHASE_RST = 2'h0;

    typedef enum logic [1:0] {ST_OFF, ST_CAPTURE, ST_COMPARE, ST_PWM} unit_state_t;

endpackage : ccp_pkg

// *** hw/duty_align.sv ***
// Forms the 10-bit pulse width from the two duty bytes.
// Assumes the alignment bit is taken from the unit's control register.
`timescale 1ns/10ps
`default_nettype none
module duty_align (
    // Duty bytes
    input  wire logic [7:0] i_high,
    input  wire logic [7:0] i_low,
    // Alignment
    input  wire logic       i_left,
    // Result
    output logic      [9:0] o_width
);
    wire logic [9:0] right_word;
    wire logic [9:0] left_word;

    assign right_word = {i_high[1:0], i_low};        // R1
    assign left_word  = {i_high, i_low[7:6]};        // R2
    assign o_width    = i_left ? left_word : right_word; // R14
endmodule : duty_align
`default_nettype wire

// *** hw/capture_trigger.sv ***
// Edge detector and edge prescaler for the capture modes.
// Assumes the capture input is synchronous to the clock.
`timescale 1ns/10ps
`default_nettype none
module capture_trigger (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_srst,
    // Control
    input  wire logic       i_clear,
    input  wire logic       i_active,
    input  wire logic [3:0] i_mode,
    // Signal
    input  wire logic       i_sig,
    output logic            o_fire
);
    logic       prev_ff;
    logic [3:0] cnt_ff;
    logic [3:0] nxt_cnt;

    function automatic logic [3:0] last_count(input logic [3:0] mode);
        if (mode == ccp_pkg::MODE_CAP_RISE16) begin
            return ccp_pkg::CAP_EVERY16_LAST;
        end
        if (mode == ccp_pkg::MODE_CAP_RISE4) begin
            return ccp_pkg::CAP_EVERY4_LAST;
        end
        return ccp_pkg::CAP_EVERY1_LAST;
    endfunction : last_count

    wire logic rise_seen = i_sig & ~prev_ff;
    wire logic fall_seen = ~i_sig & prev_ff;
    wire logic edge_seen = (i_mode == ccp_pkg::MODE_CAP_BOTH) ? (rise_seen | fall_seen) :
                           (i_mode == ccp_pkg::MODE_CAP_FALL) ? fall_seen : rise_seen; // R17
    wire logic at_last   = (cnt_ff == last_count(i_mode));

    assign nxt_cnt = (i_clear || !i_active) ? 4'h0 :
                     !edge_seen ? cnt_ff :
                     at_last ? 4'h0 : cnt_ff + 4'h1;
    assign o_fire  = i_active & edge_seen & at_last; // R17

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            prev_ff <= 1'b0;
            cnt_ff  <= 4'h0;
        end else begin
            prev_ff <= i_sig;
            cnt_ff  <= nxt_cnt;
        end
    end
endmodule : capture_trigger
`default_nettype wire

// *** hw/ccp_pwm_unit.sv ***
// One capture/compare/PWM unit with its control, duty and timer choice registers.
// Assumes three 8-bit base timers and a 16-bit capture timer outside; all inputs synchronous.
//
// Function
// [R1] Right alignment: duty top bits from high byte 1:0, rest from low byte.
// [R2] Left alignment: duty low bits from low byte 7:6, top eight from high byte.
// [R3] Duty bytes written anytime; copied to buffer only at period match.
// [R4] Time base is timer count plus two clock-phase or prescaler bits.
// [R5] Output goes low when time base equals buffered duty.
// [R6] Duty beyond period leaves the output level unchanged.
// [R7] Resolution follows period register; full ten bits at period 255.
// [R8] PWM timing derives from the system clock.
// [R9] Reset restores registers and releases the pin to input.
// [R10] Unit output routed to waveform, converter, timer reset, measure timer, logic cell.
// [R11] Control bit 7 enables the unit.
// [R12] Control bit 6 puts the output on the pin; else internal only. The pin stays undriven in capture modes and in mode 1010 (pulse).
// [R13] Control bit 5 reads the output level; writes ignored.
// [R14] Control bit 4 selects left or right duty alignment.
// [R15] Mode codes with both upper bits set select PWM.
// [R16] Compare modes: pulse, pulse with timer clear, clear, set, toggle, toggle with clear.
// [R17] Capture modes: every 16th, 4th, rising, falling, or every edge.
// [R18] Mode 0000 switches the unit off and resets its state.
// [R19] Timer choice bits 3:2 pick unit 2 base timer; 11 reserved.
// [R20] Timer choice bits 1:0 pick unit 1 base timer; 11 reserved.
// [R21] Low duty byte holds captured or compared low timer byte.
// [R22] Period match sets output unless zero duty, and loads the buffer.
// [R23] Clearing the whole control register forces the output low.
`timescale 1ns/10ps
`default_nettype none
module ccp_pwm_unit #(
    parameter int UNIT_NUMBER     = 1,
    parameter int NUM_BASE_TIMERS = 3
) (
    // Clock and reset
    input  wire logic                              i_clk,
    input  wire logic                              i_srst,
    // Register port
    input  wire logic [1:0]                        i_addr,
    input  wire logic [7:0]                        i_wdata,
    input  wire logic                              i_wr,
    input  wire logic                              i_rd,
    output logic      [7:0]                        o_rdata,
    // Base timers
    input  wire logic [NUM_BASE_TIMERS-1:0][7:0]   i_base_count,
    input  wire logic [NUM_BASE_TIMERS-1:0]        i_base_period_match,
    input  wire logic [NUM_BASE_TIMERS-1:0]        i_base_prescale_1to1,
    input  wire logic [NUM_BASE_TIMERS-1:0][1:0]   i_base_prescale_bits,
    // Capture timer
    input  wire logic [15:0]                       i_cap_timer,
    output logic                                   o_cap_timer_clear,
    // Pin
    input  wire logic                              i_pin_in,
    output logic                                   o_pin_out,
    output logic                                   o_pin_oe_n,
    // Internal consumers
    output logic                                   o_unit_output_signal,
    output logic                                   o_to_complementary_waveform_unit,
    output logic                                   o_to_converter_trigger,
    output logic                                   o_to_base_timer_reset,
    output logic                                   o_to_signal_measure_timer,
    output logic                                   o_to_configurable_logic_cell
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [7:0] ctrl_ff;
    logic [7:0] duty_low_ff;
    logic [7:0] duty_high_ff;
    logic [7:0] choice_ff;
    logic [9:0] buf_ff;
    logic [1:0] phase_ff;
    logic       out_ff;
    logic       match_prev_ff;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_ctrl;
    logic [7:0] nxt_duty_low;
    logic [7:0] nxt_duty_high;
    logic [7:0] nxt_choice;
    logic [9:0] nxt_buf;
    logic [1:0] nxt_phase;
    logic       nxt_out;
    logic [7:0] nxt_rdata;
    logic [9:0] duty_word;

    function automatic ccp_pkg::unit_state_t classify(input logic [3:0] mode);
        ccp_pkg::unit_state_t cls;
        cls = ccp_pkg::ST_CAPTURE;
        unique casez (mode)
            4'b0000: cls = ccp_pkg::ST_OFF;
            4'b11??: cls = ccp_pkg::ST_PWM;      // R15
            4'b10??: cls = ccp_pkg::ST_COMPARE;
            4'b0001: cls = ccp_pkg::ST_COMPARE;
            4'b0010: cls = ccp_pkg::ST_COMPARE;
            default: cls = ccp_pkg::ST_CAPTURE;
        endcase
        return cls;
    endfunction : classify

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    wire logic [3:0] mode      = ctrl_ff[3:0];
    wire logic       en        = ctrl_ff[ccp_pkg::CTL_EN_BIT];   // R11
    wire logic       pin_on    = ctrl_ff[ccp_pkg::CTL_OE_BIT];
    wire logic       left      = ctrl_ff[ccp_pkg::CTL_ALIGN_BIT];
    wire ccp_pkg::unit_state_t cls = classify(mode);
    wire logic       is_pwm    = en && (cls == ccp_pkg::ST_PWM);
    wire logic       is_cmp    = en && (cls == ccp_pkg::ST_COMPARE);
    wire logic       is_cap    = en && (cls == ccp_pkg::ST_CAPTURE);
    wire logic       is_off    = (cls == ccp_pkg::ST_OFF);

    wire logic       wr_ctrl   = i_wr && (i_addr == ccp_pkg::ADDR_CONTROL);
    wire logic       wr_low    = i_wr && (i_addr == ccp_pkg::ADDR_DUTY_LOW);
    wire logic       wr_high   = i_wr && (i_addr == ccp_pkg::ADDR_DUTY_HIGH);
    wire logic       wr_choice = i_wr && (i_addr == ccp_pkg::ADDR_TIMER_CHOICE);
    wire logic       ctrl_zero = wr_ctrl && (i_wdata == 8'h00);

    // ----------------------------------------
    // Base timer selection
    // ----------------------------------------
    wire logic [1:0] sel_raw   = (UNIT_NUMBER == 2) ?
                                 choice_ff[ccp_pkg::UNIT2_SEL_LSB +: 2] :  // R19
                                 choice_ff[ccp_pkg::UNIT1_SEL_LSB +: 2];   // R20
    wire logic       sel_valid = (sel_raw != ccp_pkg::TIMER_SEL_RSVD);
    wire logic [1:0] sel       = sel_valid ? sel_raw : 2'h0;
    wire logic       period_hit = is_pwm && sel_valid && i_base_period_match[sel];
    wire logic [1:0] low_bits  = i_base_prescale_1to1[sel] ? phase_ff :
                                 i_base_prescale_bits[sel];               // R4
    wire logic [9:0] time_base = {i_base_count[sel], low_bits};          // R4
    // Full 10-bit compare; a duty past the period never matches
    wire logic       duty_hit  = is_pwm && sel_valid && (time_base == buf_ff); // R5 R6 R7

    // ----------------------------------------
    // Duty alignment and capture
    // ----------------------------------------
    duty_align u_align (
        .i_high  (duty_high_ff),
        .i_low   (duty_low_ff),
        .i_left  (left),
        .o_width (duty_word)
    );

    wire logic cap_fire;
    capture_trigger u_cap (
        .i_clk    (i_clk),
        .i_srst   (i_srst),
        .i_clear  (is_off),
        .i_active (is_cap),
        .i_mode   (mode),
        .i_sig    (i_pin_in),
        .o_fire   (cap_fire)
    );

    // ----------------------------------------
    // Compare against the capture timer
    // ----------------------------------------
    wire logic cmp_match = is_cmp && ({duty_high_ff, duty_low_ff} == i_cap_timer);
    wire logic cmp_rise  = cmp_match && !match_prev_ff;
    wire logic clr_mode  = (mode == ccp_pkg::MODE_CMP_PULSE_CL) ||
                           (mode == ccp_pkg::MODE_CMP_TOGGLE_CL);
    assign o_cap_timer_clear = cmp_rise && clr_mode; // R16

    // ----------------------------------------
    // Register next values
    // ----------------------------------------
    assign nxt_ctrl      = wr_ctrl ? (i_wdata & ccp_pkg::CONTROL_WR_MASK) : ctrl_ff; // R13
    assign nxt_choice    = wr_choice ? (i_wdata & ccp_pkg::TIMER_CHOICE_MASK) : choice_ff;
    // Capture wins over a software write in the same cycle
    assign nxt_duty_low  = cap_fire ? i_cap_timer[7:0] :
                           wr_low ? i_wdata : duty_low_ff;  // R21 R3
    assign nxt_duty_high = cap_fire ? i_cap_timer[15:8] :
                           wr_high ? i_wdata : duty_high_ff;
    assign nxt_buf       = is_off ? 10'h000 :
                           period_hit ? duty_word : buf_ff; // R3 R22 R18
    // Clock phase inside one timer tick, realigned at each period
    assign nxt_phase     = (is_off || period_hit) ? ccp_pkg::SYSCLK_PHASE_RST :
                           phase_ff + 2'h1;                 // R8

    always_comb begin
        nxt_out = out_ff;
        if (ctrl_zero || is_off) begin
            nxt_out = 1'b0; // R23 R18
        end else if (is_pwm) begin
            if (period_hit) begin
                nxt_out = (duty_word != 10'h000); // R22
            end else if (duty_hit) begin
                nxt_out = 1'b0; // R5
            end
        end else if (is_cmp) begin
            unique case (mode)
                ccp_pkg::MODE_CMP_PULSE,
                ccp_pkg::MODE_CMP_PULSE_CL: nxt_out = cmp_match; // R16
                ccp_pkg::MODE_CMP_SET: begin
                    if (cmp_rise) nxt_out = 1'b1;
                end
                ccp_pkg::MODE_CMP_CLEAR: begin
                    if (cmp_rise) nxt_out = 1'b0;
                end
                ccp_pkg::MODE_CMP_TOGGLE,
                ccp_pkg::MODE_CMP_TOGGLE_CL: begin
                    if (cmp_rise) nxt_out = ~out_ff;
                end
                default: nxt_out = out_ff;
            endcase
        end
    end

    assign nxt_rdata = !i_rd ? 8'h00 :
        (i_addr == ccp_pkg::ADDR_CONTROL)  ? (ctrl_ff | ({7'h00, out_ff} << ccp_pkg::CTL_OUT_BIT)) : // R13
        (i_addr == ccp_pkg::ADDR_DUTY_LOW) ? duty_low_ff :
        (i_addr == ccp_pkg::ADDR_DUTY_HIGH) ? duty_high_ff : choice_ff;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            ctrl_ff       <= ccp_pkg::CONTROL_RST; // R9
            duty_low_ff   <= ccp_pkg::DUTY_RST;
            duty_high_ff  <= ccp_pkg::DUTY_RST;
            choice_ff     <= ccp_pkg::TIMER_CHOICE_RST;
            buf_ff        <= 10'h000;
            phase_ff      <= ccp_pkg::SYSCLK_PHASE_RST;
            out_ff        <= 1'b0;
            match_prev_ff <= 1'b0;
            rdata_ff      <= 8'h00;
        end else begin
            ctrl_ff       <= nxt_ctrl;
            duty_low_ff   <= nxt_duty_low;
            duty_high_ff  <= nxt_duty_high;
            choice_ff     <= nxt_choice;
            buf_ff        <= nxt_buf;
            phase_ff      <= nxt_phase;
            out_ff        <= nxt_out;
            match_prev_ff <= cmp_match;
            rdata_ff      <= nxt_rdata;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    wire logic drives_pin = pin_on && en && !is_cap && (mode != ccp_pkg::MODE_CMP_PULSE);
    assign o_rdata                          = rdata_ff;
    assign o_pin_out                        = out_ff;
    assign o_pin_oe_n                       = ~drives_pin; // R12 R9
    assign o_unit_output_signal             = out_ff;      // R10
    assign o_to_complementary_waveform_unit = out_ff;
    assign o_to_converter_trigger           = out_ff;
    assign o_to_base_timer_reset            = out_ff;
    assign o_to_signal_measure_timer        = out_ff;
    assign o_to_configurable_logic_cell     = out_ff;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_right_align_load: assert property ( // R1
        @(posedge i_clk) disable iff (i_srst)
        (period_hit && !left) |=> (buf_ff == {$past(duty_high_ff[1:0]), $past(duty_low_ff)}))
        else $error("right aligned duty not latched");

    chk_left_align_load: assert property ( // R2
        @(posedge i_clk) disable iff (i_srst)
        (period_hit && left) |=> (buf_ff == {$past(duty_high_ff), $past(duty_low_ff[7:6])}))
        else $error("left aligned duty not latched");

    chk_buffer_holds: assert property ( // R3
        @(posedge i_clk) disable iff (i_srst)
        (!period_hit && !is_off) |=> (buf_ff == $past(buf_ff)))
        else $error("duty buffer changed outside period match");

    chk_duty_clears_out: assert property ( // R5
        @(posedge i_clk) disable iff (i_srst)
        (duty_hit && !period_hit && !ctrl_zero) |=> !out_ff)
        else $error("output not cleared at duty match");

    chk_period_sets_out: assert property ( // R22
        @(posedge i_clk) disable iff (i_srst)
        (period_hit && !ctrl_zero) |=> (out_ff == ($past(duty_word) != 10'h000)))
        else $error("period match output level wrong");

    chk_out_readback: assert property ( // R13
        @(posedge i_clk) disable iff (i_srst)
        (i_rd && (i_addr == ccp_pkg::ADDR_CONTROL)) |=> (o_rdata[ccp_pkg::CTL_OUT_BIT] == $past(out_ff)))
        else $error("control read does not show output level");

    chk_ctrl_clear_low: assert property ( // R23
        @(posedge i_clk) disable iff (i_srst)
        ctrl_zero |=> (!out_ff && !o_to_base_timer_reset) ##1 !out_ff)
        else $error("cleared control did not force output low");

    chk_reset_pin_input: assert property ( // R9
        @(posedge i_clk) disable iff (i_srst)
        $past(i_srst) |-> (o_pin_oe_n && (ctrl_ff == ccp_pkg::CONTROL_RST)))
        else $error("pin not released after reset");

    chk_timer_clear_cause: assert property ( // R16
        @(posedge i_clk) disable iff (i_srst)
        o_cap_timer_clear |-> (clr_mode && ({duty_high_ff, duty_low_ff} == i_cap_timer)))
        else $error("capture timer cleared without match");

    chk_capture_loads: assert property ( // R21
        @(posedge i_clk) disable iff (i_srst)
        cap_fire |=> (duty_low_ff == $past(i_cap_timer[7:0]) && duty_high_ff == $past(i_cap_timer[15:8])))
        else $error("capture did not load timer value");

    chk_reserved_timer: assert property ( // R19 R20
        @(posedge i_clk) disable iff (i_srst)
        !sel_valid |-> (!period_hit && !duty_hit))
        else $error("reserved timer choice produced PWM events");

endmodule : ccp_pwm_unit
`default_nettype wire

// *** sim/base_timer_model.sv ***
// Model of the three 8-bit base timers that drive the unit.
// Assumes one shared clock and a 1:1 prescaler on every timer.
`timescale 1ns/10ps
`default_nettype none
module base_timer_model #(
    parameter logic [23:0] PERIODS = 24'h0B070F
) (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_srst,
    // Timer state
    output logic [2:0][7:0] o_count,
    output logic [2:0]      o_match,
    output logic [2:0]      o_pre_1to1,
    output logic [2:0][1:0] o_pre_bits
);
    logic [1:0] phase_ff;
    // Count advances once every four system clocks
    always_ff @(posedge i_clk) begin
        phase_ff <= i_srst ? 2'h0 : phase_ff + 2'h1;
        for (int i = 0; i < 3; i++) begin
            if (i_srst || o_match[i]) o_count[i] <= 8'h00;
            else if (phase_ff == 2'h3) o_count[i] <= o_count[i] + 8'h01;
        end
    end
    always_comb begin
        for (int i = 0; i < 3; i++) o_match[i] = (phase_ff == 2'h3) && (o_count[i] == PERIODS[8*i +: 8]);
    end
    assign o_pre_1to1 = 3'h7;
    assign o_pre_bits = 6'h00;
endmodule : base_timer_model
`default_nettype wire

// *** sim/tb_ccp_pwm_duty_and_control.sv ***
// Self-checking bench for one capture/compare/PWM unit.
// Assumes the base timer model with periods 15, 7 and 11.
`timescale 1ns/10ps
`default_nettype none
module tb_ccp_pwm_duty_and_control;
    logic clk = 0, srst = 1, wr = 0, rd = 0, pin_in = 0;
    logic [1:0] addr = 0;
    logic [7:0] wdata = 0, rdata;
    logic [15:0] cap = 0;
    logic [2:0][7:0] cnt;
    logic [2:0] match, p11;
    logic [2:0][1:0] pbits;
    logic clr, pin_out, oe_n, out, t_cwu, t_conv, t_rst, t_smt, t_clc;
    int miscompares = 0, checked = 0, hi;
    always #5 clk = ~clk;
    base_timer_model base_timer_model_inst (.i_clk(clk), .i_srst(srst), .o_count(cnt), .o_match(match),
        .o_pre_1to1(p11), .o_pre_bits(pbits));
    ccp_pwm_unit ccp_pwm_unit_inst (.i_clk(clk), .i_srst(srst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .i_base_count(cnt), .i_base_period_match(match),
        .i_base_prescale_1to1(p11), .i_base_prescale_bits(pbits), .i_cap_timer(cap),
        .o_cap_timer_clear(clr), .i_pin_in(pin_in), .o_pin_out(pin_out), .o_pin_oe_n(oe_n),
        .o_unit_output_signal(out), .o_to_complementary_waveform_unit(t_cwu),
        .o_to_converter_trigger(t_conv), .o_to_base_timer_reset(t_rst),
        .o_to_signal_measure_timer(t_smt), .o_to_configurable_logic_cell(t_clc));
    task automatic check_val(string nm, logic [7:0] exp, logic [7:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : check_val
    task automatic reg_wr(logic [1:0] a, logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1;
        @(posedge clk);
        wr <= 0;
    endtask : reg_wr
    task automatic reg_rd(logic [1:0] a, logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1;
        @(posedge clk);
        rd <= 0;
        #1 check_val("rdata", e, rdata);
    endtask : reg_rd
    // Counts high cycles over one period, optionally rewriting duty low mid-pulse
    task automatic measure(int s, int n, bit wt, bit wmid, int e);
        int k;
        k = 0;
        hi = 0;
        while (wt && k < 300) begin
            @(posedge clk);
            #1 k = (match[s] === 1'b1) ? 300 : k + 1;
        end
        for (int i = 1; i <= n; i++) begin
            @(posedge clk);
            if (wmid && i == 2) begin
                addr <= 2'h1;
                wdata <= 8'h0A;
            end
            wr <= wmid && i == 2;
            #1 hi += (out === 1'b1);
        end
        check_val("high cycles", 8'(e), 8'(hi));
    endtask : measure
    task automatic pwm(logic [7:0] h, logic [7:0] l, logic [7:0] c, int s, int n, int e);
        reg_wr(2'h2, h);
        reg_wr(2'h1, l);
        reg_wr(2'h0, c);
        measure(s, n, 1, 0, e);
    endtask : pwm
    task automatic give_verdict();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict
    initial begin
        #200000 miscompares++;
        give_verdict();
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        srst <= 0;
        for (int a = 0; a < 4; a++) reg_rd(2'(a), 8'h00);
        check_val("oe_n", 8'h01, {7'h0, oe_n});
        reg_wr(2'h3, 8'hFF);
        reg_rd(2'h3, 8'h0F);
        reg_wr(2'h3, 8'h00);
        reg_wr(2'h0, 8'h20);
        reg_rd(2'h0, 8'h00);
        for (int m = 0; m < 4; m++) pwm(8'h00, 8'h04, 8'hCC | 8'(m), 0, 64, 5);
        check_val("oe_n", 8'h00, {7'h0, oe_n});
        // Mid-run reset while the pin is driven
        @(posedge clk);
        srst <= 1;
        repeat (2) @(posedge clk);
        srst <= 0;
        @(posedge clk);
        #1 check_val("oe_n", 8'h01, {7'h0, oe_n});
        reg_rd(2'h0, 8'h00);
        pwm(8'h01, 8'h40, 8'hDC, 0, 64, 6);
        pwm(8'h00, 8'h00, 8'hCC, 0, 64, 0);
        pwm(8'h03, 8'hFF, 8'hCC, 0, 64, 64);
        pwm(8'h00, 8'h04, 8'hCC, 0, 64, 5);
        measure(0, 64, 1, 1, 5);
        measure(0, 64, 1, 0, 11);
        reg_wr(2'h3, 8'h0D);
        pwm(8'h00, 8'h04, 8'hCC, 1, 32, 5);
        reg_wr(2'h0, 8'h00);
        repeat (2) @(posedge clk);
        #1 check_val("out", 8'h00, {7'h0, out});
        reg_wr(2'h3, 8'h03);
        reg_wr(2'h0, 8'h8C);
        #1 check_val("oe_n", 8'h01, {7'h0, oe_n});
        measure(0, 64, 0, 0, 0);
        reg_wr(2'h2, 8'h00);
        reg_wr(2'h1, 8'h20);
        reg_wr(2'h0, 8'h88);
        cap <= 16'h0020;
        repeat (3) @(posedge clk);
        #1 check_val("routes", 8'h1F, {3'h0, t_cwu, t_conv, t_rst, t_smt, t_clc});
        reg_wr(2'h0, 8'h80);
        repeat (2) @(posedge clk);
        #1 check_val("out", 8'h00, {7'h0, out});
        reg_wr(2'h0, 8'h85);
        cap <= 16'h1234;
        pin_in <= 1;
        repeat (3) @(posedge clk);
        reg_rd(2'h1, 8'h34);
        reg_rd(2'h2, 8'h12);
        // Pulse with timer clear: duty bytes already equal the timer
        reg_wr(2'h0, 8'h8B);
        #1 check_val("cap clear", 8'h01, {7'h0, clr});
        @(posedge clk);
        #1 check_val("pin", 8'h01, {7'h0, pin_out});
        @(posedge clk);
        cap <= 16'h0000;
        repeat (2) @(posedge clk);
        #1 check_val("pin", 8'h00, {7'h0, pin_out});
        give_verdict();
    end
endmodule : tb_ccp_pwm_duty_and_control
`default_nettype wire
